//--- logic/cpl_loop.sv
// Purpose: carrier phase error detector and second-order loop filter
// Assumes: i_phase from the polar converter on the same clock
// Notes:   serial word goes MSB first, sync high with the first bit
//
// Local design decisions: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
module cpl_loop
  import cpl_pkg::*;
(
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  // phase stream
  input  wire logic [ERR_W-1:0]  i_phase,
  input  wire logic              i_phase_vld,
  input  wire logic              i_end_symbol,
  input  wire logic              i_carrier_freeze_in,
  // extra loop terms
  input  wire logic [ACC_W-1:0]  i_afc_term,
  input  wire logic [ACC_W-1:0]  i_sweep_term,
  // avalon-mm slave
  input  wire logic [7:0]        i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [31:0]       i_avs_writedata,
  output logic      [31:0]       o_avs_readdata,
  output logic                   o_avs_waitrequest,
  // results
  output logic      [ERR_W-1:0]  o_data_out,
  output logic      [ACC_W-1:0]  o_filter_out,
  output logic      [NCO_W-1:0]  o_nco_freq,
  output logic                   o_nco_freq_vld,
  output logic                   o_carrier_freq_serial_out,
  output logic                   o_carrier_freq_word_sync
);
  // ******************************************************************
  // registers
  // ******************************************************************
  cpl_ped_s          ped_q;
  cpl_gain_s         lead_g_q, lag_g_q;
  logic [2:0]        cfg_q;
  logic [3:0]        osel_q;
  logic [ACC_W-1:0]  uplim_q, lolim_q, pre_q;
  logic [7:0]        snap_q;
  logic              wait_q;
  logic [31:0]       rdata_q;
  wire               req     = i_avs_read | i_avs_write;
  wire               wr_acc  = i_avs_write & ~wait_q;
  wire               wr_load = wr_acc & (i_avs_address == ADR_CMD) & i_avs_writedata[0];
  logic [ACC_W-1:0]  lag_q;
  wire  [31:0]       rd_mux =
    (i_avs_address == ADR_PED_CTRL)  ? {26'h0, ped_q} :
    (i_avs_address == ADR_CFG)       ? {29'h0, cfg_q} :
    (i_avs_address == ADR_LEAD_GAIN) ? {23'h0, lead_g_q} :
    (i_avs_address == ADR_LAG_GAIN)  ? {23'h0, lag_g_q} :
    (i_avs_address == ADR_UPLIM_LO)  ? uplim_q[31:0] :
    (i_avs_address == ADR_UPLIM_HI)  ? {24'h0, uplim_q[39:32]} :
    (i_avs_address == ADR_LOLIM_LO)  ? lolim_q[31:0] :
    (i_avs_address == ADR_LOLIM_HI)  ? {24'h0, lolim_q[39:32]} :
    (i_avs_address == ADR_PRE_LO)    ? pre_q[31:0] :
    (i_avs_address == ADR_PRE_HI)    ? {24'h0, pre_q[39:32]} :
    (i_avs_address == ADR_LAG_LO)    ? lag_q[31:0] :
    (i_avs_address == ADR_LAG_HI)    ? {24'h0, snap_q} :
    (i_avs_address == ADR_OUT_SEL)   ? {28'h0, osel_q} : RD_ZERO;

  // one wait cycle, then the request is accepted
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      wait_q  <= 1'b1;
      rdata_q <= RD_ZERO;
    end
    else
    begin
      wait_q <= ~(req & wait_q);
      if (req & wait_q)
        rdata_q <= rd_mux;
    end
  end

  // high byte frozen on the same edge that captures the low word
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      snap_q <= 8'h00;
    else if (wait_q & i_avs_read & (i_avs_address == ADR_LAG_LO))
      snap_q <= lag_q[39:32];
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ped_q    <= '0;
      cfg_q    <= 3'h0;
      lead_g_q <= '0;
      lag_g_q  <= '0;
      uplim_q  <= UPLIM_RST;
      lolim_q  <= LOLIM_RST;
      pre_q    <= '0;
      osel_q   <= OSEL_PHASE;
    end
    else if (wr_acc)
    begin
      if (i_avs_address == ADR_PED_CTRL)
        ped_q <= i_avs_writedata[5:0];
      else if (i_avs_address == ADR_CFG)
        cfg_q <= i_avs_writedata[2:0];
      else if (i_avs_address == ADR_LEAD_GAIN)
        lead_g_q <= i_avs_writedata[8:0];
      else if (i_avs_address == ADR_LAG_GAIN)
        lag_g_q <= i_avs_writedata[8:0];
      else if (i_avs_address == ADR_UPLIM_LO)
        uplim_q[31:0] <= i_avs_writedata;
      else if (i_avs_address == ADR_UPLIM_HI)
        uplim_q[39:32] <= i_avs_writedata[7:0];
      else if (i_avs_address == ADR_LOLIM_LO)
        lolim_q[31:0] <= i_avs_writedata;
      else if (i_avs_address == ADR_LOLIM_HI)
        lolim_q[39:32] <= i_avs_writedata[7:0];
      else if (i_avs_address == ADR_PRE_LO)
        pre_q[31:0] <= i_avs_writedata;
      else if (i_avs_address == ADR_PRE_HI)
        pre_q[39:32] <= i_avs_writedata[7:0];
      else if (i_avs_address == ADR_OUT_SEL)
        osel_q <= i_avs_writedata[3:0];
    end
  end

  // ******************************************************************
  // freeze pin synchroniser
  // ******************************************************************
  logic [2:0] frz_sync_q;
  logic       frz_q;
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      frz_sync_q <= 3'h0;
      frz_q      <= 1'b0;
    end
    else
    begin
      frz_sync_q <= {frz_sync_q[1:0], i_carrier_freeze_in};
      if (frz_sync_q[1] == frz_sync_q[2])
        frz_q <= frz_sync_q[2];
    end
  end

  // ******************************************************************
  // phase error detector
  // ******************************************************************
  wire  [3:0]       rot_hi = i_phase[7:4] + ped_q.offset;
  wire  [7:0]       det_w  = {rot_hi, i_phase[3:0]} << ped_q.shift;
  wire              take_w = i_phase_vld & (~cfg_q[CFG_IANDD] | i_end_symbol);
  logic [ERR_W-1:0] err_q;
  logic             err_vld_q;
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      err_q     <= 8'h00;
      err_vld_q <= 1'b0;
    end
    else
    begin
      err_vld_q <= take_w;
      if (take_w)
        err_q <= det_w;
    end
  end

  // ******************************************************************
  // error accumulator and filter input
  // ******************************************************************
  cpl_state_e        st_q;
  logic [ERR_W-1:0]  acc_q, fin_q;
  logic              pend_q;
  wire               start  = (st_q == ST_IDLE) & pend_q;
  wire  [ERR_W:0]    acc_sum = {acc_q[7], acc_q} + {err_q[7], err_q};
  wire  [ERR_W-1:0]  acc_sat = (acc_sum[8] != acc_sum[7]) ?
                               (acc_sum[8] ? 8'h80 : 8'h7F) : acc_sum[7:0];
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      acc_q  <= 8'h00;
      pend_q <= 1'b0;
      fin_q  <= 8'h00;
    end
    else
    begin
      if (start)
        fin_q <= frz_q ? 8'h00 : acc_q;
      // consumed error never lingers into a later accumulating run
      if (start)
        acc_q <= err_vld_q ? err_q : 8'h00;
      else if (err_vld_q & cfg_q[CFG_ACC_EN])
        acc_q <= acc_sat;
      else if (err_vld_q & ~pend_q)
        acc_q <= err_q;
      pend_q <= err_vld_q | (pend_q & ~start);
    end
  end

  // ******************************************************************
  // gain and alignment
  // ******************************************************************
  function automatic logic [ACC_W-1:0] scale(input logic [ERR_W-1:0] e, input cpl_gain_s g);
    logic signed [PROD_W-1:0] p;
    logic        [WIDE_W-1:0] w;
    p = $signed(e) * $signed({1'b0, 1'b1, g.mant});
    w = {{(WIDE_W-PROD_W){p[PROD_W-1]}}, p} << g.expo;
    return w[ACC_W+ALIGN_DROP-1:ALIGN_DROP];
  endfunction

  // ******************************************************************
  // six-edge loop filter sequence
  // ******************************************************************
  logic [ACC_W-1:0]  lead_q, lagt_q, out_q;
  logic [ACC_W:0]    lsum_q;
  wire  [ACC_W:0]    up_x = {uplim_q[39], uplim_q};
  wire  [ACC_W:0]    lo_x = {lolim_q[39], lolim_q};
  wire               over = $signed(lsum_q) > $signed(up_x);
  wire               undr = $signed(lsum_q) < $signed(lo_x);
  wire  [ACC_W-1:0]  out_w = lag_q + lead_q + i_afc_term + i_sweep_term;
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      st_q <= ST_IDLE;
    else
      case (st_q)
        ST_IDLE: st_q <= start ? ST_MUL : ST_IDLE;
        ST_MUL:  st_q <= ST_LAG;
        ST_LAG:  st_q <= ST_LIM;
        ST_LIM:  st_q <= ST_SUM;
        ST_SUM:  st_q <= ST_OUT;
        default: st_q <= ST_IDLE;
      endcase
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      lead_q <= '0;
      lagt_q <= '0;
      lsum_q <= '0;
      lag_q  <= '0;
      out_q  <= '0;
    end
    else
    begin
      if (st_q == ST_MUL)
      begin
        lead_q <= scale(fin_q, lead_g_q);
        lagt_q <= scale(fin_q, lag_g_q);
      end
      if (st_q == ST_LAG)
        lsum_q <= {lag_q[39], lag_q} + {lagt_q[39], lagt_q};
      // host preload outranks the limiter update
      if (wr_load)
        lag_q <= pre_q;
      else if (st_q == ST_LIM)
        lag_q <= over ? uplim_q : (undr ? lolim_q : lsum_q[39:0]);
      if (st_q == ST_SUM)
        out_q <= out_w;
    end
  end

  // ******************************************************************
  // outputs: on-chip nco, serial word, data selector
  // ******************************************************************
  logic [NCO_W-1:0] ser_q;
  logic [5:0]       scnt_q;
  logic             sbusy_q;
  wire              ser_ld = (st_q == ST_OUT) & ~cfg_q[CFG_ONCHIP] & ~sbusy_q;
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_filter_out   <= '0;
      o_nco_freq     <= '0;
      o_nco_freq_vld <= 1'b0;
      o_data_out     <= 8'h00;
    end
    else
    begin
      o_nco_freq_vld <= (st_q == ST_OUT) & cfg_q[CFG_ONCHIP];
      if (st_q == ST_OUT)
        o_filter_out <= out_q;
      if ((st_q == ST_OUT) & cfg_q[CFG_ONCHIP])
        o_nco_freq <= out_q[ACC_W-1:ACC_W-NCO_W];
      o_data_out <= (osel_q == OSEL_PHASE) ? err_q :
                    (osel_q == OSEL_NCO) ? o_nco_freq[31:24] : 8'h00;
    end
  end

  // a word that arrives while one is still shifting is skipped
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ser_q   <= '0;
      scnt_q  <= 6'h00;
      sbusy_q <= 1'b0;
      o_carrier_freq_serial_out <= 1'b0;
      o_carrier_freq_word_sync  <= 1'b0;
    end
    else
    begin
      o_carrier_freq_word_sync <= ser_ld;
      if (ser_ld)
      begin
        ser_q   <= {out_q[38:8], 1'b0};
        scnt_q  <= 6'h00;
        sbusy_q <= 1'b1;
        o_carrier_freq_serial_out <= out_q[39];
      end
      else if (sbusy_q)
      begin
        o_carrier_freq_serial_out <= ser_q[NCO_W-1];
        ser_q   <= {ser_q[NCO_W-2:0], 1'b0};
        scnt_q  <= scnt_q + 6'h01;
        sbusy_q <= (scnt_q != SER_LAST - 6'h01);
      end
    end
  end

  assign o_avs_readdata    = rdata_q;
  assign o_avs_waitrequest = wait_q;

  // ******************************************************************
  // assertions
  // ******************************************************************
  sequence s_run;
    (st_q != ST_IDLE) [*5] ##1 (st_q == ST_IDLE);
  endsequence
  property p_det;
    @(posedge i_clk) disable iff (i_rst)
    take_w |=> err_q == 8'(({$past(i_phase[7:4]) + $past(ped_q.offset),
                             $past(i_phase[3:0])}) << $past(ped_q.shift));
  endproperty
  a_det: assert property (p_det) else $error("detector output wrong");
  property p_six;
    @(posedge i_clk) disable iff (i_rst) start |=> s_run;
  endproperty
  a_six: assert property (p_six) else $error("filter cycle not six edges");
  property p_iandd;
    @(posedge i_clk) disable iff (i_rst)
    cfg_q[CFG_IANDD] & i_phase_vld & ~i_end_symbol |=> ~err_vld_q;
  endproperty
  a_iandd: assert property (p_iandd) else $error("mid-symbol error taken");
  property p_restart;
    @(posedge i_clk) disable iff (i_rst)
    start & cfg_q[CFG_ACC_EN] & ~err_vld_q |=> acc_q == 8'h00;
  endproperty
  a_restart: assert property (p_restart) else $error("accumulator not restarted");
  property p_frz;
    @(posedge i_clk) disable iff (i_rst) start & frz_q |=> fin_q == 8'h00;
  endproperty
  a_frz: assert property (p_frz) else $error("frozen error not zero");
  property p_lim;
    @(posedge i_clk) disable iff (i_rst)
    (st_q == ST_LIM) & ~wr_load & $signed(uplim_q) >= $signed(lolim_q) |=>
      $signed(lag_q) <= $signed($past(uplim_q)) && $signed(lag_q) >= $signed($past(lolim_q));
  endproperty
  a_lim: assert property (p_lim) else $error("lag outside limits");
  property p_pre;
    @(posedge i_clk) disable iff (i_rst) wr_load |=> lag_q == $past(pre_q);
  endproperty
  a_pre: assert property (p_pre) else $error("preload lost");
  property p_nco;
    @(posedge i_clk) disable iff (i_rst)
    (st_q == ST_OUT) & cfg_q[CFG_ONCHIP] |=> o_nco_freq_vld && o_nco_freq == $past(out_q[39:8]);
  endproperty
  a_nco: assert property (p_nco) else $error("nco word wrong");
  property p_ser;
    @(posedge i_clk) disable iff (i_rst)
    o_carrier_freq_word_sync |=> (~o_carrier_freq_word_sync) [*8];
  endproperty
  a_ser: assert property (p_ser) else $error("serial sync too soon");
  property p_sel;
    @(posedge i_clk) disable iff (i_rst) osel_q == OSEL_PHASE |=> o_data_out == $past(err_q);
  endproperty
  a_sel: assert property (p_sel) else $error("selector not routing error");
endmodule // cpl_loop

//--- logic/cpl_pkg.sv
// Purpose: constants and types for the carrier phase error loop filter
// Assumes: one 40 MHz clock, Avalon-MM register access
// Notes:   offsets are byte addresses of 32-bit words
// Behaviour
// - rotate phase by adding 4-bit signed offset to the top phase nibble
// - then shift left 0..3 places, dropping top bits, zero filling low bits
// - CW 00h/0, BPSK 00h/1, QPSK 20h/2, 8-PSK 10h/3 offset and shift
// - one phase error per I/Q sample entering the polar converter
// - filter cycle takes six edges; optional accumulator sums errors between inputs
// - with integrate-and-dump input only end-symbol errors reach the filter
// - output is lag accumulator plus lead term plus AFC and sweep terms
// - lead and lag mantissa scales input by 1 + M/16
// - 5-bit exponent scales by 2^-(32-E)
// - filter input is 8-bit fractional two's complement error
// - 40-bit fractional output, top 32 bits are the NCO word
// - lag accumulator beyond a limit is loaded with that limit
// - freeze input forces the filter input error to zero
// - host can preload and read back the lag accumulator
// - on-chip NCO mode feeds filter output to the NCO
// - otherwise send the word on serial output with sync
// - detector offset and shift live in control bits 0 to 5
// - output selector bits 0 to 3 route phase error to data out
// - lag path weights error by lag gain and integrates it
package cpl_pkg;
  localparam int          ACC_W         = 40;
  localparam int          ERR_W         = 8;
  localparam int          NCO_W         = 32;
  localparam int          PROD_W        = 13;
  localparam int          WIDE_W        = 48;
  localparam int          ALIGN_DROP    = 4;
  // ********************************************************************
  // register map
  // ********************************************************************
  localparam logic [7:0]  ADR_PED_CTRL  = 8'h00;
  localparam logic [7:0]  ADR_CFG       = 8'h04;
  localparam logic [7:0]  ADR_LEAD_GAIN = 8'h08;
  localparam logic [7:0]  ADR_LAG_GAIN  = 8'h0C;
  localparam logic [7:0]  ADR_UPLIM_LO  = 8'h10;
  localparam logic [7:0]  ADR_UPLIM_HI  = 8'h14;
  localparam logic [7:0]  ADR_LOLIM_LO  = 8'h18;
  localparam logic [7:0]  ADR_LOLIM_HI  = 8'h1C;
  localparam logic [7:0]  ADR_PRE_LO    = 8'h20;
  localparam logic [7:0]  ADR_PRE_HI    = 8'h24;
  localparam logic [7:0]  ADR_CMD       = 8'h28;
  localparam logic [7:0]  ADR_LAG_LO    = 8'h2C;
  localparam logic [7:0]  ADR_LAG_HI    = 8'h30;
  localparam logic [7:0]  ADR_OUT_SEL   = 8'h34;
  localparam int          CFG_ACC_EN    = 0;
  localparam int          CFG_IANDD     = 1;
  localparam int          CFG_ONCHIP    = 2;
  localparam logic [3:0]  OSEL_PHASE    = 4'h0;
  localparam logic [3:0]  OSEL_NCO      = 4'h1;
  localparam logic [39:0] UPLIM_RST     = 40'h7FFFFFFFFF;
  localparam logic [39:0] LOLIM_RST     = 40'h8000000000;
  localparam logic [31:0] RD_ZERO       = 32'h0000_0000;
  localparam logic [5:0]  SER_LAST      = 6'h1F;
  typedef struct packed {
    logic [1:0] shift;
    logic [3:0] offset;
  } cpl_ped_s;
  typedef struct packed {
    logic [4:0] expo;
    logic [3:0] mant;
  } cpl_gain_s;
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_MUL  = 6'b000010,
    ST_LAG  = 6'b000100,
    ST_LIM  = 6'b001000,
    ST_SUM  = 6'b010000,
    ST_OUT  = 6'b100000
  } cpl_state_e;
endpackage

//--- testbench/cpl_tuner_model.sv
// Purpose: far-end tuner that loads the serial carrier frequency word
// Assumes: word arrives msb first, sync high with the first bit
// Notes:   receive only; o_words counts complete words
`timescale 1ns/1ps
module cpl_tuner_model
  import cpl_pkg::*;
(
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  // serial link from the loop filter
  input  wire logic              i_ser,
  input  wire logic              i_sync,
  // loaded synthesizer word
  output logic      [NCO_W-1:0]  o_word,
  output logic      [15:0]       o_words
);
  logic [NCO_W-1:0] sh_q;
  logic [5:0]       cnt_q;

  // ********************************************************************
  // shift in and load the synthesizer word
  // ********************************************************************
  // a sync in mid-word restarts the frame, like a real loader would
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      sh_q    <= '0;
      cnt_q   <= 6'h00;
      o_word  <= '0;
      o_words <= 16'h0000;
    end
    else if (i_sync)
    begin
      sh_q  <= {31'h0, i_ser};
      cnt_q <= 6'h01;
    end
    else if (cnt_q != 6'h00)
    begin
      sh_q <= {sh_q[30:0], i_ser};
      if (cnt_q == SER_LAST)
      begin
        o_word  <= {sh_q[30:0], i_ser};
        o_words <= o_words + 16'h0001;
        cnt_q   <= 6'h00;
      end
      else
        cnt_q <= cnt_q + 6'h01;
    end
  end
endmodule // cpl_tuner_model

//--- testbench/carrier_phase_error_loop_filter_tb.sv
// Purpose: self-checking bench for the carrier loop filter
// Assumes: avalon-mm with one wait cycle, on-chip or serial output
// Notes:   expectations are built from gain arithmetic in the bench
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin fail_count++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, gt); end end
module carrier_phase_error_loop_filter_tb;
  import cpl_pkg::*;
  logic              clk, rst, pvld, eos, frz, rd, wr, wreq, nvld, ser, sync;
  logic [7:0]        phase, addr, dout;
  logic [31:0]       wdata, rdata, rv, nco, word;
  logic [39:0]       afc, swp, fout, exp_lag, exp_out, lagv;
  logic [15:0]       words, n;
  int                fail_count, compares;
  logic [5:0]        ped_tab [5] = '{6'h00, 6'h10, 6'h22, 6'h31, 6'h0F};
  logic [7:0]        err_tab [5] = '{8'h5A, 8'hB4, 8'hE8, 8'h50, 8'h4A};
  logic [7:0]        ph_tab  [2] = '{8'h10, 8'hF0};

  cpl_loop i_cpl_loop (
    .i_clk(clk), .i_rst(rst), .i_phase(phase), .i_phase_vld(pvld), .i_end_symbol(eos),
    .i_carrier_freeze_in(frz), .i_afc_term(afc), .i_sweep_term(swp),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .o_data_out(dout),
    .o_filter_out(fout), .o_nco_freq(nco), .o_nco_freq_vld(nvld),
    .o_carrier_freq_serial_out(ser), .o_carrier_freq_word_sync(sync));

  cpl_tuner_model i_cpl_tuner_model (
    .i_clk(clk), .i_rst(rst), .i_ser(ser), .i_sync(sync), .o_word(word), .o_words(words));

  // ********************************************************************
  // helpers
  // ********************************************************************
  // sign-extended error times (16+m), shifted by x, bits 43:4 kept
  function automatic logic [39:0] term(input logic [7:0] e, input logic [3:0] m,
                                       input logic [4:0] x);
    logic [47:0] p;
    p = {{40{e[7]}}, e} * {43'h0, 1'b1, m};
    p = p << x;
    return p[43:4];
  endfunction

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic r, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    rd    <= r;
    wr    <= !r;
    do
    begin
      @(posedge clk);
      t++;
    end
    while (wreq !== 1'b0 && t < 50);
    rv = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (wreq !== 1'b0)
    begin
      fail_count++;
      test_done();
    end
  endtask

  task automatic preload(input logic [39:0] v);
    bus(1'b0, ADR_PRE_LO, v[31:0]);
    bus(1'b0, ADR_PRE_HI, {24'h0, v[39:32]});
    bus(1'b0, ADR_CMD, 32'h1);
  endtask

  task automatic rd_lag();
    bus(1'b1, ADR_LAG_LO, 32'h0);
    lagv[31:0] = rv;
    bus(1'b1, ADR_LAG_HI, 32'h0);
    lagv[39:32] = rv[7:0];
  endtask

  task automatic pulse(input logic [7:0] ph, input logic es);
    @(posedge clk);
    phase <= ph;
    pvld  <= 1'b1;
    eos   <= es;
    @(posedge clk);
    pvld  <= 1'b0;
    eos   <= 1'b0;
  endtask

  // waits for the filter cycle to finish; outputs are read at that edge
  task automatic run(input logic [7:0] ph, input logic es);
    int t;
    pulse(ph, es);
    t = 0;
    do
    begin
      @(posedge clk);
      t++;
    end
    while (nvld !== 1'b1 && t < 40);
    `CHK("nco_valid", 1'b1, nvld)
  endtask

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    test_done();
  end

  // ********************************************************************
  // tests
  // ********************************************************************
  initial
  begin
    {rst, pvld, eos, frz, rd, wr} = 6'b100000;
    phase = 8'h00;
    addr  = 8'h00;
    wdata = 32'h0;
    afc   = 40'h00_0000_0300;
    swp   = 40'h00_0001_0000;
    repeat (8) @(posedge clk);
    `CHK("waitreq_reset", 1'b1, wreq)
    `CHK("filter_out_reset", 40'h0, fout)
    rst <= 1'b0;
    bus(1'b1, ADR_UPLIM_LO, 32'h0);
    `CHK("uplim_lo", 32'hFFFF_FFFF, rv)
    bus(1'b1, ADR_UPLIM_HI, 32'h0);
    `CHK("uplim_hi", 8'h7F, rv[7:0])
    bus(1'b1, ADR_LOLIM_HI, 32'h0);
    `CHK("lolim_hi", 8'h80, rv[7:0])
    bus(1'b1, 8'h3C, 32'h0);
    `CHK("unmapped", 32'h0, rv)
    bus(1'b0, ADR_OUT_SEL, 32'h0);
    for (int k = 0; k < 5; k++)
    begin
      bus(1'b0, ADR_PED_CTRL, {26'h0, ped_tab[k]});
      pulse(8'h5A, 1'b0);
      repeat (4) @(posedge clk);
      `CHK("phase_error", err_tab[k], dout)
    end
    bus(1'b0, ADR_PED_CTRL, 32'h0);
    bus(1'b0, ADR_CFG, 32'h4);
    bus(1'b0, ADR_LEAD_GAIN, 32'h1C5);
    bus(1'b0, ADR_LAG_GAIN, 32'h080);
    exp_lag = 40'h00_1234_5678;
    preload(exp_lag);
    rd_lag();
    `CHK("lag_preload", exp_lag, lagv)
    for (int k = 0; k < 2; k++)
    begin
      exp_lag = exp_lag + term(ph_tab[k], 4'h0, 5'd8);
      exp_out = exp_lag + term(ph_tab[k], 4'h5, 5'd28) + afc + swp;
      run(ph_tab[k], 1'b0);
      `CHK("filter_out", exp_out, fout)
      `CHK("nco_word", exp_out[39:8], nco)
      rd_lag();
      `CHK("lag_acc", exp_lag, lagv)
    end
    bus(1'b0, ADR_OUT_SEL, 32'h1);
    repeat (3) @(posedge clk);
    `CHK("data_out_nco", exp_out[39:32], dout)
    bus(1'b0, ADR_OUT_SEL, 32'h0);
    frz <= 1'b1;
    repeat (8) @(posedge clk);
    run(8'h40, 1'b0);
    `CHK("frozen_out", exp_lag + afc + swp, fout)
    frz <= 1'b0;
    repeat (8) @(posedge clk);
    bus(1'b0, ADR_CFG, 32'h6);
    pulse(8'h20, 1'b0);
    repeat (20) @(posedge clk);
    rd_lag();
    `CHK("iandd_skip", exp_lag, lagv)
    exp_lag = exp_lag + term(8'h20, 4'h0, 5'd8);
    run(8'h20, 1'b1);
    rd_lag();
    `CHK("iandd_end", exp_lag, lagv)
    bus(1'b0, ADR_CFG, 32'h5);
    preload(40'h0);
    @(posedge clk);
    phase <= 8'h01;
    pvld  <= 1'b1;
    @(posedge clk);
    phase <= 8'h02;
    @(posedge clk);
    phase <= 8'h03;
    @(posedge clk);
    pvld  <= 1'b0;
    repeat (30) @(posedge clk);
    rd_lag();
    `CHK("acc_sum", term(8'h06, 4'h0, 5'd8), lagv)
    bus(1'b0, ADR_CFG, 32'h0);
    exp_lag = 40'h00_0ABC_0000;
    preload(exp_lag);
    n = words;
    pulse(8'h08, 1'b0);
    for (int t = 0; t < 100 && words == n; t++)
      @(posedge clk);
    exp_out = exp_lag + term(8'h08, 4'h0, 5'd8) + term(8'h08, 4'h5, 5'd28) + afc + swp;
    `CHK("serial_word", exp_out[39:8], word)
    bus(1'b0, ADR_CFG, 32'h4);
    bus(1'b0, ADR_UPLIM_LO, 32'h100);
    bus(1'b0, ADR_UPLIM_HI, 32'h0);
    preload(40'hF0);
    run(8'h10, 1'b0);
    rd_lag();
    `CHK("upper_limit", 40'h100, lagv)
    bus(1'b0, ADR_LOLIM_LO, 32'hFFFF_FF00);
    bus(1'b0, ADR_LOLIM_HI, 32'hFF);
    preload(40'h0);
    run(8'h80, 1'b0);
    rd_lag();
    `CHK("lower_limit", 40'hFF_FFFF_FF00, lagv)
    test_done();
  end
endmodule // carrier_phase_error_loop_filter_tb
